//--- common/fcl_pkg.sv
// fcl_pkg: register map, field layout and timing constants of the flash
// command launch and ecc capture block.
// assumes a 32-bit axi4-lite slave with one register per aligned word.
package fcl_pkg;

	// register indices as printed; byte address is four times the index
	localparam logic [7:0] FCL_IDX_DIV = 8'h00;
	localparam logic [7:0] FCL_IDX_ECC_RESULT_INDEX = 8'h02;
	localparam logic [7:0] FCL_IDX_PARIX = 8'h01;
	localparam logic [7:0] FCL_IDX_STAT = 8'h06;
	localparam logic [7:0] FCL_IDX_PARAM = 8'h0A;
	localparam logic [7:0] FCL_IDX_RSV1 = 8'h0D;
	localparam logic [7:0] FCL_IDX_ECCR = 8'h0E;
	localparam logic [7:0] FCL_IDX_OPT = 8'h10;
	localparam logic [7:0] FCL_IDX_RSV2 = 8'h11;
	localparam logic [7:0] FCL_IDX_RSV3 = 8'h12;
	localparam logic [7:0] FCL_IDX_RSV4 = 8'h13;
	localparam logic [7:0] FCL_IDX_ECCSTAT = 8'h14;
	localparam int FCL_AW = 8;

	// divider register fields
	localparam int FCL_DIV_W = 7;
	localparam int FCL_DIVLD_BIT = 7;
	// status register fields
	localparam int FCL_COMMAND_COMPLETE_FLAG_BIT = 7;
	localparam int FCL_ACCESS_ERROR_FLAG_BIT = 5;
	localparam int FCL_PVIOL_BIT = 4;
	// ecc status fields (write one to clear)
	localparam int FCL_SFDIF_BIT = 0;
	localparam int FCL_DFDIF_BIT = 1;

	localparam int FCL_IX_W = 3;
	localparam int FCL_PARAM_WORDS = 6;
	localparam int FCL_CMD_HI = 15;
	localparam int FCL_CMD_LO = 8;

	localparam logic [2:0] FCL_ECC_PAR_ADDR = 3'h0;
	localparam logic [2:0] FCL_ECC_ADDR_LO = 3'h1;
	localparam logic [2:0] FCL_ECC_DATA0 = 3'h2;
	localparam logic [2:0] FCL_ECC_DATA3 = 3'h5;

	localparam logic [7:0] FCL_OPT_FAULT = 8'hFF;
	localparam logic [7:0] FCL_DFLASH_PAR_MASK = 8'h3F;

	// program and erase command codes, which need the time base
	localparam logic [7:0] FCL_CMD_PGM_P = 8'h06;
	localparam logic [7:0] FCL_CMD_PGM_ONCE = 8'h07;
	localparam logic [7:0] FCL_CMD_ERS_ALL = 8'h08;
	localparam logic [7:0] FCL_CMD_ERS_BLK = 8'h09;
	localparam logic [7:0] FCL_CMD_ERS_PSEC = 8'h0A;
	localparam logic [7:0] FCL_CMD_UNSEC = 8'h0B;
	localparam logic [7:0] FCL_CMD_PGM_D = 8'h11;
	localparam logic [7:0] FCL_CMD_ERS_DSEC = 8'h12;

	localparam logic [1:0] FCL_RESP_OKAY = 2'h0;
	localparam logic [1:0] FCL_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		FCL_OPT_LOAD = 2'b00,
		FCL_OPT_WAIT = 2'b01,
		FCL_OPT_DONE = 2'b11
	} fcl_opt_t;

endpackage

//--- verilog/fcl_time_base.sv
// fcl_time_base: divides the bus clock into a one-cycle flash time base
// enable. assumes divisor = value+1 bus cycles, counted only when enabled.
module fcl_time_base
	import fcl_pkg::*;
(
	input wire logic aclk, // bus clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic run, // divider has been loaded
	input wire logic [FCL_DIV_W-1:0] divisor, // divider value field
	output logic tick // one-cycle time base enable
);
	logic [FCL_DIV_W-1:0] count;
	logic [FCL_DIV_W-1:0] next_count;
	logic next_tick;

	always_comb begin
		next_count = count;
		next_tick = 1'b0;
		if (!run) begin
			next_count = '0;
		end else if (count >= divisor) begin
			next_count = '0;
			next_tick = 1'b1;
		end else begin
			next_count = count + 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count <= '0;
			tick <= 1'b0;
		end else begin
			count <= next_count;
			tick <= next_tick;
		end
	end
endmodule // fcl_time_base

//--- verilog/fcl_flash_ctrl.sv
// fcl_flash_ctrl: register side of the flash controller: ecc fault capture
// window, option byte load, divider load flag and command launch handshake.
// assumes an axi4-lite master and a memory controller that pulses cmd_done.
// Functional notes
// - factory reserved registers read zero, ignore writes
// - ecc window word chosen by result index
// - capture frozen until both fault flags cleared
// - double fault wins over simultaneous single fault
// - ecc window readable, writes have no effect
// - index zero: parity, zero, upper address bits
// - indices six and seven read zero
// - data-array parity keeps six bits, top zero
// - program fault: address low, four raw words
// - data fault: address low, one raw word
// - option register read-only, loaded once after reset
// - double fault on option read sets all ones
// - divider write sets loaded flag, reset clears
// - unloaded divider: program/erase refused, access error
// - busy: no launch, parameter writes ignored
// - writing one to complete flag launches command
// - flag stays low until done, results kept
// - word zero high byte holds command code
// - parameter indices six, seven ignore writes, read zero
module fcl_flash_ctrl
	import fcl_pkg::*;
(
	input wire logic aclk, // bus clock, 10 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [FCL_AW+1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [FCL_AW+1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic opt_valid, // option phrase read finished
	input wire logic [7:0] opt_byte, // option byte from array
	input wire logic opt_dbl_fault, // double fault on option phrase
	input wire logic ecc_single, // single fault pulse
	input wire logic ecc_double, // double fault pulse
	input wire logic ecc_dflash, // fault is in the data array
	input wire logic [22:0] ecc_addr, // faulting global address
	input wire logic [7:0] ecc_par, // raw check bits
	input wire logic [63:0] ecc_data, // raw phrase, word 0 in low bits
	input wire logic prot_viol, // protection violation pulse
	input wire logic cmd_done, // command finished pulse
	input wire logic [15:0] result_data [FCL_PARAM_WORDS], // results
	output logic cmd_start, // one-cycle launch pulse
	output logic [15:0] cmd_param [FCL_PARAM_WORDS], // locked parameters
	output logic flash_tick // flash time base enable
);
	// write channel state
	logic aw_held, w_held, bvalid;
	logic next_aw_held, next_w_held, next_bvalid;
	logic [FCL_AW+1:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic [1:0] bresp, next_bresp;
	// read channel state
	logic rvalid, next_rvalid;
	logic [31:0] rdata, next_rdata;
	logic [1:0] rresp, next_rresp;
	// registers
	logic [FCL_DIV_W-1:0] div_val, next_div_val;
	logic div_loaded, next_div_loaded;
	logic [FCL_IX_W-1:0] ecc_ix, next_ecc_ix;
	logic [FCL_IX_W-1:0] par_ix, next_par_ix;
	logic command_complete_flag, next_command_complete_flag;
	logic access_error_flag, next_access_error_flag;
	logic pviol, next_pviol;
	logic sfault, next_sfault;
	logic dfault, next_dfault;
	logic [15:0] param [FCL_PARAM_WORDS];
	logic [15:0] next_param [FCL_PARAM_WORDS];
	logic [7:0] opt, next_opt;
	fcl_opt_t opt_state, next_opt_state;
	logic start, next_start;
	// captured fault
	logic cap_dflash, next_cap_dflash;
	logic [22:0] cap_addr, next_cap_addr;
	logic [7:0] cap_par, next_cap_par;
	logic [63:0] cap_data, next_cap_data;

	logic wr_go, rd_go;
	logic [FCL_AW-1:0] w_idx, r_idx;
	logic [7:0] wb;
	logic [15:0] ecc_word, par_word;
	logic [7:0] cmd_code;
	logic is_pe;

	fcl_time_base u_time_base (
		.aclk(aclk),
		.aresetn(aresetn),
		.run(div_loaded),
		.divisor(div_val),
		.tick(flash_tick)
	);

	assign s_axi_awready = !aw_held && !bvalid;
	assign s_axi_wready = !w_held && !bvalid;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rdata = rdata;
	assign s_axi_rresp = rresp;
	assign cmd_start = start;
	assign cmd_param = param;

	assign wr_go = aw_held && w_held && !bvalid;
	assign rd_go = s_axi_arvalid && !rvalid;
	assign w_idx = aw_addr[FCL_AW+1:2];
	assign r_idx = s_axi_araddr[FCL_AW+1:2];
	assign wb = w_data[7:0];
	assign cmd_code = param[0][FCL_CMD_HI:FCL_CMD_LO];

	always_comb begin
		unique case (cmd_code)
			FCL_CMD_PGM_P, FCL_CMD_PGM_ONCE, FCL_CMD_ERS_ALL,
			FCL_CMD_ERS_BLK, FCL_CMD_ERS_PSEC, FCL_CMD_UNSEC,
			FCL_CMD_PGM_D, FCL_CMD_ERS_DSEC: is_pe = 1'b1;
			default: is_pe = 1'b0;
		endcase
	end

	// ecc result window mux
	always_comb begin
		ecc_word = 16'h0000;
		if (ecc_ix == FCL_ECC_PAR_ADDR) begin
			ecc_word = {cap_dflash ? (cap_par & FCL_DFLASH_PAR_MASK) : cap_par,
				1'b0, cap_addr[22:16]};
		end else if (ecc_ix == FCL_ECC_ADDR_LO) begin
			ecc_word = cap_addr[15:0];
		end else if (ecc_ix == FCL_ECC_DATA0) begin
			ecc_word = cap_data[15:0];
		end else if (ecc_ix <= FCL_ECC_DATA3 && !cap_dflash) begin
			ecc_word = cap_data[16*(ecc_ix-FCL_ECC_DATA0) +: 16];
		end
	end

	always_comb begin
		par_word = 16'h0000;
		if (par_ix < FCL_IX_W'(FCL_PARAM_WORDS)) begin
			par_word = param[par_ix];
		end
	end

	// bus channels
	always_comb begin
		next_aw_held = aw_held;
		next_w_held = w_held;
		next_aw_addr = aw_addr;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid;
		next_bresp = bresp;
		next_rvalid = rvalid;
		next_rdata = rdata;
		next_rresp = rresp;
		if (s_axi_awvalid && s_axi_awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_w_held = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (wr_go) begin
			next_aw_held = 1'b0;
			next_w_held = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = FCL_RESP_OKAY;
			unique case (w_idx)
				FCL_IDX_DIV, FCL_IDX_ECC_RESULT_INDEX, FCL_IDX_PARIX, FCL_IDX_STAT,
				FCL_IDX_PARAM, FCL_IDX_ECCSTAT, FCL_IDX_RSV1, FCL_IDX_ECCR,
				FCL_IDX_OPT, FCL_IDX_RSV2, FCL_IDX_RSV3,
				FCL_IDX_RSV4: next_bresp = FCL_RESP_OKAY;
				default: next_bresp = FCL_RESP_SLVERR;
			endcase
		end
		if (bvalid && s_axi_bready) begin
			next_bvalid = 1'b0;
		end
		if (rd_go) begin
			next_rvalid = 1'b1;
			next_rresp = FCL_RESP_OKAY;
			next_rdata = 32'h0000_0000;
			unique case (r_idx)
				FCL_IDX_DIV: next_rdata[7:0] = {div_loaded, div_val};
				FCL_IDX_ECC_RESULT_INDEX: next_rdata[FCL_IX_W-1:0] = ecc_ix;
				FCL_IDX_PARIX: next_rdata[FCL_IX_W-1:0] = par_ix;
				FCL_IDX_STAT: begin
					next_rdata[FCL_COMMAND_COMPLETE_FLAG_BIT] = command_complete_flag;
					next_rdata[FCL_ACCESS_ERROR_FLAG_BIT] = access_error_flag;
					next_rdata[FCL_PVIOL_BIT] = pviol;
				end
				FCL_IDX_PARAM: next_rdata[15:0] = par_word;
				FCL_IDX_ECCR: next_rdata[15:0] = ecc_word;
				FCL_IDX_OPT: next_rdata[7:0] = opt;
				FCL_IDX_ECCSTAT: begin
					next_rdata[FCL_SFDIF_BIT] = sfault;
					next_rdata[FCL_DFDIF_BIT] = dfault;
				end
				FCL_IDX_RSV1, FCL_IDX_RSV2, FCL_IDX_RSV3,
				FCL_IDX_RSV4: next_rdata = 32'h0000_0000;
				default: next_rresp = FCL_RESP_SLVERR;
			endcase
		end else if (rvalid && s_axi_rready) begin
			next_rvalid = 1'b0;
		end
	end

	// registers, launch and capture
	always_comb begin
		next_div_val = div_val;
		next_div_loaded = div_loaded;
		next_ecc_ix = ecc_ix;
		next_par_ix = par_ix;
		next_command_complete_flag = command_complete_flag;
		next_access_error_flag = access_error_flag;
		next_pviol = pviol;
		next_sfault = sfault;
		next_dfault = dfault;
		next_param = param;
		next_start = 1'b0;
		next_cap_dflash = cap_dflash;
		next_cap_addr = cap_addr;
		next_cap_par = cap_par;
		next_cap_data = cap_data;
		if (wr_go && w_strb[0]) begin
			unique case (w_idx)
				FCL_IDX_DIV: begin
					next_div_val = wb[FCL_DIV_W-1:0];
					next_div_loaded = 1'b1;
				end
				FCL_IDX_ECC_RESULT_INDEX: next_ecc_ix = wb[FCL_IX_W-1:0];
				FCL_IDX_PARIX: next_par_ix = wb[FCL_IX_W-1:0];
				FCL_IDX_STAT: begin
					if (wb[FCL_ACCESS_ERROR_FLAG_BIT]) next_access_error_flag = 1'b0;
					if (wb[FCL_PVIOL_BIT]) next_pviol = 1'b0;
					// launch needs idle and clear errors
					if (wb[FCL_COMMAND_COMPLETE_FLAG_BIT] && command_complete_flag && !access_error_flag && !pviol) begin
						if (!div_loaded && is_pe) begin
							next_access_error_flag = 1'b1;
						end else begin
							next_command_complete_flag = 1'b0;
							next_start = 1'b1;
						end
					end
				end
				FCL_IDX_ECCSTAT: begin
					if (wb[FCL_SFDIF_BIT]) next_sfault = 1'b0;
					if (wb[FCL_DFDIF_BIT]) next_dfault = 1'b0;
				end
				default: ;
			endcase
		end
		// parameter writes, ignored while busy or beyond the array
		if (wr_go && w_idx == FCL_IDX_PARAM && command_complete_flag &&
			par_ix < FCL_IX_W'(FCL_PARAM_WORDS)) begin
			if (w_strb[0]) next_param[par_ix][7:0] = w_data[7:0];
			if (w_strb[1]) next_param[par_ix][15:8] = w_data[15:8];
		end
		if (cmd_done && !command_complete_flag) begin
			next_command_complete_flag = 1'b1;
			next_param = result_data;
		end
		if (prot_viol) next_pviol = 1'b1;
		// capture only while no fault flag holds earlier details
		if ((ecc_single || ecc_double) && !sfault && !dfault) begin
			next_cap_dflash = ecc_dflash;
			next_cap_addr = ecc_addr;
			next_cap_par = ecc_par;
			next_cap_data = ecc_data;
			if (ecc_double) next_dfault = 1'b1;
			else next_sfault = 1'b1;
		end else begin
			// set wins over a clear in the same cycle
			if (ecc_double) next_dfault = 1'b1;
			if (ecc_single) next_sfault = 1'b1;
		end
	end

	// option byte load
	always_comb begin
		next_opt = opt;
		next_opt_state = opt_state;
		unique case (opt_state)
			FCL_OPT_LOAD: next_opt_state = FCL_OPT_WAIT;
			FCL_OPT_WAIT: begin
				if (opt_valid) begin
					next_opt = opt_dbl_fault ? FCL_OPT_FAULT : opt_byte;
					next_opt_state = FCL_OPT_DONE;
				end
			end
			FCL_OPT_DONE: next_opt_state = FCL_OPT_DONE;
			default: next_opt_state = FCL_OPT_LOAD;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= '0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= FCL_RESP_OKAY;
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= FCL_RESP_OKAY;
			div_val <= '0;
			div_loaded <= 1'b0;
			ecc_ix <= '0;
			par_ix <= '0;
			command_complete_flag <= 1'b1;
			access_error_flag <= 1'b0;
			pviol <= 1'b0;
			sfault <= 1'b0;
			dfault <= 1'b0;
			for (int i = 0; i < FCL_PARAM_WORDS; i++) param[i] <= 16'h0000;
			start <= 1'b0;
			opt <= 8'h00;
			opt_state <= FCL_OPT_LOAD;
			cap_dflash <= 1'b0;
			cap_addr <= '0;
			cap_par <= 8'h00;
			cap_data <= '0;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rdata <= next_rdata;
			rresp <= next_rresp;
			div_val <= next_div_val;
			div_loaded <= next_div_loaded;
			ecc_ix <= next_ecc_ix;
			par_ix <= next_par_ix;
			command_complete_flag <= next_command_complete_flag;
			access_error_flag <= next_access_error_flag;
			pviol <= next_pviol;
			sfault <= next_sfault;
			dfault <= next_dfault;
			param <= next_param;
			start <= next_start;
			opt <= next_opt;
			opt_state <= next_opt_state;
			cap_dflash <= next_cap_dflash;
			cap_addr <= next_cap_addr;
			cap_par <= next_cap_par;
			cap_data <= next_cap_data;
		end
	end
endmodule // fcl_flash_ctrl

//--- tb/fcl_flash_ctrl_checker.sv
// fcl_flash_ctrl_checker: port-level assertions for the flash control block.
// assumes it is bound into fcl_flash_ctrl and sees only its ports.
module fcl_flash_ctrl_checker
	import fcl_pkg::*;
(
	input wire logic aclk, // bus clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [FCL_AW+1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic [31:0] s_axi_rdata, // read data
	input wire logic s_axi_bvalid, // write response valid
	input wire logic opt_valid, // option read done
	input wire logic [7:0] opt_byte, // option byte
	input wire logic opt_dbl_fault, // option double fault
	input wire logic cmd_done, // command finished
	input wire logic [15:0] result_data [FCL_PARAM_WORDS], // results
	input wire logic cmd_start, // launch pulse
	input wire logic [15:0] cmd_param [FCL_PARAM_WORDS] // parameters
);
	timeunit 1ns;
	timeprecision 1ns;
	logic busy, next_busy, opt_seen, next_opt_seen, rsv_hit;
	logic [7:0] opt_exp, next_opt_exp, rd_idx;
	assign rd_idx = s_axi_araddr[FCL_AW+1:2];
	assign rsv_hit = rd_idx inside {FCL_IDX_RSV1, FCL_IDX_RSV2, FCL_IDX_RSV3,
		FCL_IDX_RSV4};
	// only the first option read after reset counts, later ones are ignored
	always_comb begin
		next_busy = cmd_start | (busy & ~cmd_done);
		next_opt_seen = opt_seen | opt_valid;
		next_opt_exp = opt_exp;
		if (opt_valid && !opt_seen) begin
			next_opt_exp = opt_dbl_fault ? FCL_OPT_FAULT : opt_byte;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy <= 1'h0;
			opt_seen <= 1'h0;
			opt_exp <= 8'h00;
		end else begin
			busy <= next_busy;
			opt_seen <= next_opt_seen;
			opt_exp <= next_opt_exp;
		end
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence s_read(logic [7:0] idx);
		s_axi_arvalid && s_axi_arready && rd_idx == idx;
	endsequence
	a_start_pulse: assert property (cmd_start |=> !cmd_start)
		else $error("launch pulse longer than one cycle");
	a_start_resp: assert property (cmd_start |-> $rose(s_axi_bvalid))
		else $error("launch not tied to a status write");
	a_no_relaunch: assert property (busy |-> !cmd_start)
		else $error("second launch while busy");
	a_params_lock: assert property (busy && !cmd_done |=>
		$stable(cmd_param[0]) && $stable(cmd_param[2]))
		else $error("parameters changed while busy");
	a_results_kept: assert property (busy && cmd_done |=>
		cmd_param[0] == $past(result_data[0]) &&
		cmd_param[5] == $past(result_data[5]))
		else $error("results not returned to parameter array");
	a_busy_flag_low: assert property (busy ##0 s_read(FCL_IDX_STAT) |=>
		!s_axi_rdata[FCL_COMMAND_COMPLETE_FLAG_BIT])
		else $error("complete flag read high while busy");
	a_reserved_zero: assert property (s_axi_arvalid &&
		s_axi_arready && rsv_hit |=> s_axi_rdata == 32'h0)
		else $error("reserved register read nonzero");
	a_option_val: assert property (opt_seen ##0 s_read(FCL_IDX_OPT) |=>
		s_axi_rdata == {24'h0, opt_exp})
		else $error("option register value wrong");
endmodule // fcl_flash_ctrl_checker

bind fcl_flash_ctrl fcl_flash_ctrl_checker u_chk (.*);

//--- tb/fcl_flash_ctrl_tb.sv
// fcl_flash_ctrl_tb: self-checking bench for the flash control block.
// assumes the checker is bound in; bench plays bus master and array side.
module fcl_flash_ctrl_tb
	import fcl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic aclk = '0, aresetn = '0;
	logic [FCL_AW+1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_arvalid = '0;
	logic s_axi_bready = 1'h1, s_axi_rready = 1'h1;
	logic [31:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, cmd_start, flash_tick, rtake, btake;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic opt_valid = '0, opt_dbl_fault = '0, ecc_single = '0;
	logic ecc_double = '0, ecc_dflash = '0, prot_viol = '0, cmd_done = '0;
	logic [7:0] opt_byte = '0, ecc_par = '0, opt_b, cp;
	logic [22:0] ecc_addr = '0, ca;
	logic [63:0] ecc_data = '0, cd;
	logic cdf;
	logic [15:0] result_data [FCL_PARAM_WORDS] = '{default: '0};
	logic [15:0] cmd_param [FCL_PARAM_WORDS];
	logic [7:0] rsv [4] = '{FCL_IDX_RSV1, FCL_IDX_RSV2, FCL_IDX_RSV3,
		FCL_IDX_RSV4};
	int fails = 0, n_checks = 0, n_starts = 0;
	int seed = 32'hd49ef490;
	logic [31:0] rq [$];
	logic [1:0] bq [$];
	logic [1:0] rrq [$];
	logic [95:0] pq [$];

	fcl_flash_ctrl dut (.*);

	always #50 aclk = ~aclk;
	assign rtake = aresetn & s_axi_rvalid & s_axi_rready;
	assign btake = aresetn & s_axi_bvalid & s_axi_bready;

	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("Error %s expected %h seen %h", what, e, g);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic expire();
		fails++;
		$display("Error handshake expected answer seen none");
		close_out();
	endtask
	// results are judged off the clock edge, where all outputs have settled
	always @(negedge aclk) begin
		if (rtake) chk("rdata", rq.pop_front(), s_axi_rdata);
		if (rtake) chk("rresp", 32'(rrq.pop_front()), 32'(s_axi_rresp));
		if (btake) chk("bresp", 32'(bq.pop_front()), 32'(s_axi_bresp));
		if (aresetn && cmd_start) begin
			n_starts++;
			for (int k = 0; k < FCL_PARAM_WORDS; k++) begin
				chk("param", 32'(pq[0][k*16+:16]), 32'(cmd_param[k]));
			end
			void'(pq.pop_front());
		end
	end
	task automatic wr(input logic [7:0] idx, input logic [31:0] d,
		input logic [1:0] r = FCL_RESP_OKAY);
		logic a, w, b;
		int i;
		bq.push_back(r);
		s_axi_awaddr <= {idx, 2'h0};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(negedge aclk);
			a = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid;
			@(posedge aclk);
			if (a) s_axi_awvalid <= '0;
			if (w) s_axi_wvalid <= '0;
			if (b) break;
		end
		if (i == 50) expire();
	endtask
	task automatic rd(input logic [7:0] idx, input logic [31:0] e,
		input logic [1:0] rr = FCL_RESP_OKAY);
		logic a, r;
		int i;
		rq.push_back(e);
		rrq.push_back(rr);
		s_axi_araddr <= {idx, 2'h0};
		s_axi_arvalid <= 1'h1;
		for (i = 0; i < 50; i++) begin
			@(negedge aclk);
			a = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid;
			@(posedge aclk);
			if (a) s_axi_arvalid <= '0;
			if (r) break;
		end
		if (i == 50) expire();
	endtask
	task automatic do_reset(input logic dbl);
		aresetn <= '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (3) @(posedge aclk);
		opt_b = 8'($random(seed));
		opt_byte <= opt_b;
		opt_dbl_fault <= dbl;
		opt_valid <= 1'h1;
		@(posedge aclk);
		opt_valid <= '0;
	endtask
	task automatic ecc_hit(input logic s, dd, df, keep);
		logic [22:0] a;
		logic [7:0] p;
		logic [63:0] d;
		a = 23'($random(seed));
		p = 8'($random(seed));
		d = {$random(seed), $random(seed)};
		ecc_addr <= a;
		ecc_par <= p;
		ecc_data <= d;
		ecc_dflash <= df;
		ecc_single <= s;
		ecc_double <= dd;
		@(posedge aclk);
		ecc_single <= '0;
		ecc_double <= '0;
		if (!keep) begin
			ca = a;
			cp = df ? (p & FCL_DFLASH_PAR_MASK) : p;
			cd = d;
			cdf = df;
		end
	endtask
	task automatic ecc_chk();
		logic [15:0] e;
		for (int i = 0; i < 8; i++) begin
			case (i)
				0: e = {cp, 1'h0, ca[22:16]};
				1: e = ca[15:0];
				6, 7: e = '0;
				default: e = cd[(i-2)*16+:16];
			endcase
			if (cdf && i > 2 && i < 6) continue;
			wr(FCL_IDX_ECC_RESULT_INDEX, 32'(i));
			rd(FCL_IDX_ECCR, {16'h0, e});
		end
	endtask

	initial begin
		logic [95:0] pv, rv;
		logic [15:0] w;
		logic [6:0] dv;
		int i, t;
		do_reset(1'h0);
		rd(FCL_IDX_OPT, {24'h0, opt_b});
		wr(FCL_IDX_OPT, 32'h0000_00FF);
		rd(FCL_IDX_OPT, {24'h0, opt_b});
		foreach (rsv[k]) begin
			wr(rsv[k], $random(seed));
			rd(rsv[k], '0);
		end
		wr(8'h3F, 32'h1, FCL_RESP_SLVERR);
		rd(8'h3F, '0, FCL_RESP_SLVERR);
		rd(FCL_IDX_DIV, '0);
		wr(FCL_IDX_PARIX, '0);
		wr(FCL_IDX_PARAM, {16'h0, FCL_CMD_PGM_P, 8'h00});
		wr(FCL_IDX_STAT, 32'h80);
		rd(FCL_IDX_STAT, 32'hA0);
		wr(FCL_IDX_STAT, 32'h20);
		prot_viol <= 1'h1;
		@(posedge aclk);
		prot_viol <= '0;
		wr(FCL_IDX_STAT, 32'h80);
		rd(FCL_IDX_STAT, 32'h90);
		wr(FCL_IDX_STAT, 32'h10);
		chk("starts", 0, n_starts);
		dv = 7'($random(seed)) & 7'h07;
		wr(FCL_IDX_DIV, {25'h0, dv});
		rd(FCL_IDX_DIV, {24'h0, 1'h1, dv});
		// time base period is the divider value plus one bus cycle
		for (i = 0; i < 200 && flash_tick !== 1'h1; i++) @(negedge aclk);
		for (t = 0; t < 200; t++) begin
			@(negedge aclk);
			if (flash_tick === 1'h1) break;
		end
		if (i == 200 || t == 200) expire();
		chk("tick", 32'(dv) + 1, t + 1);
		@(posedge aclk);
		pv = {$random(seed), $random(seed), $random(seed)};
		pv[15:8] = FCL_CMD_PGM_P;
		for (i = 0; i < 8; i++) begin
			w = i < 6 ? pv[i*16+:16] : 16'($random(seed));
			wr(FCL_IDX_PARIX, 32'(i));
			wr(FCL_IDX_PARAM, {16'h0, w});
			rd(FCL_IDX_PARAM, i < 6 ? {16'h0, w} : '0);
		end
		pq.push_back(pv);
		wr(FCL_IDX_STAT, 32'h80);
		rd(FCL_IDX_STAT, '0);
		wr(FCL_IDX_PARIX, '0);
		wr(FCL_IDX_PARAM, 32'h1234);
		rd(FCL_IDX_PARAM, {16'h0, pv[15:0]});
		wr(FCL_IDX_STAT, 32'h80);
		chk("starts", 1, n_starts);
		rv = {$random(seed), $random(seed), $random(seed)};
		foreach (result_data[k]) result_data[k] <= rv[k*16+:16];
		cmd_done <= 1'h1;
		@(posedge aclk);
		cmd_done <= '0;
		rd(FCL_IDX_STAT, 32'h80);
		for (i = 0; i < 6; i++) begin
			wr(FCL_IDX_PARIX, 32'(i));
			rd(FCL_IDX_PARAM, {16'h0, rv[i*16+:16]});
		end
		ecc_hit(1'h0, 1'h1, 1'h0, 1'h0);
		ecc_chk();
		ecc_hit(1'h1, 1'h0, 1'h1, 1'h1);
		wr(FCL_IDX_ECCR, 32'hFFFF);
		ecc_chk();
		rd(FCL_IDX_ECCSTAT, 32'h3);
		wr(FCL_IDX_ECCSTAT, 32'h3);
		rd(FCL_IDX_ECCSTAT, '0);
		ecc_hit(1'h1, 1'h0, 1'h1, 1'h0);
		ecc_chk();
		wr(FCL_IDX_ECCSTAT, 32'h3);
		ecc_hit(1'h1, 1'h1, 1'h0, 1'h0);
		rd(FCL_IDX_ECCSTAT, 32'h2);
		ecc_chk();
		do_reset(1'h1);
		rd(FCL_IDX_OPT, 32'hFF);
		rd(FCL_IDX_DIV, '0);
		// code zero needs no time base, so it starts unloaded
		pq.push_back('0);
		wr(FCL_IDX_STAT, 32'h80);
		chk("starts", 2, n_starts);
		close_out();
	end
endmodule // fcl_flash_ctrl_tb
